/* design/clock_source_pkg.sv */
// clock source unit: shared constants, register map and state types
// assumes one 10 MHz system clock; source clocks arrive as one-cycle tick strobes
package clock_source_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
    localparam logic [3:0] ADDR_CTRL_TWO = 4'h4;
    localparam logic [3:0] ADDR_TRIM = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SRC_SEL_HI = 7;
    localparam int SRC_SEL_LO = 6;
    localparam int REF_DIV_HI = 5;
    localparam int REF_DIV_LO = 3;
    localparam int REF_SEL_BIT = 2;
    localparam int INT_OUT_EN_BIT = 1;
    localparam int INT_STOP_EN_BIT = 0;
    localparam int BUS_DIV_HI = 7;
    localparam int BUS_DIV_LO = 6;
    localparam int RANGE_BIT = 5;
    localparam int HIGH_GAIN_BIT = 4;
    localparam int LOW_POWER_BIT = 3;
    localparam int OSC_SEL_BIT = 2;
    localparam int EXT_OUT_EN_BIT = 1;
    localparam int EXT_STOP_EN_BIT = 0;
    localparam int FINE_TRIM_BIT = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h40;
    localparam logic [7:0] COARSE_TRIM_POR = 8'h80;
    localparam logic FINE_TRIM_POR = 1'b0;
    localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // clock source codes and divider constants
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;
    localparam logic [2:0] REF_DIV_CODE_128 = 3'h6;
    localparam logic [2:0] REF_DIV_LOG2_128 = 3'h7;
    localparam logic [2:0] DEBUG_DIV_LOG2 = 3'h1;
    localparam logic [2:0] BUS_HALF_LOG2 = 3'h1;

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_LOOP_ENGAGED_INTERNAL = 3'h0,
        MODE_LOOP_BYPASSED_INTERNAL = 3'h1,
        MODE_BYPASSED_INTERNAL_LOW_POWER = 3'h3,
        MODE_LOOP_ENGAGED_EXTERNAL = 3'h2,
        MODE_LOOP_BYPASSED_EXTERNAL = 3'h6,
        MODE_BYPASSED_EXTERNAL_LOW_POWER = 3'h7,
        MODE_STOP = 3'h5
    } mode_t;

    typedef enum logic [1:0] {
        SW_RUN = 2'h0,
        SW_DRAIN = 2'h1,
        SW_ARM = 2'h3
    } switch_state_t;

endpackage : clock_source_pkg

/* design/tick_divider.sv */
// power-of-two divider for tick strobes
// assumes log2Div never exceeds CW; output is one registered pulse
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int CW = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic tickIn,
    input wire logic [2:0] log2Div,
    output logic tickOut
);
    import clock_source_pkg::*;

    logic [CW-1:0] countReg;
    logic [CW-1:0] mask;

    always_comb begin
        mask = CW'((32'h1 << log2Div) - 32'h1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            countReg <= '0;
            tickOut <= 1'b0;
        end else if (clkEn) begin
            tickOut <= 1'b0;
            if (tickIn) begin
                // only masked bits matter, so a shrinking ratio cannot hang it
                if ((countReg & mask) == mask) begin
                    countReg <= '0;
                    tickOut <= 1'b1;
                end else begin
                    countReg <= countReg + CW'(1);
                end
            end
        end
    end
endmodule : tick_divider
`default_nettype wire

/* design/clock_switch.sv */
// glitch-free selector between three tick sources
// assumes reqSel never holds the reserved code; caller folds it to the loop
`timescale 1ns/1ps
`default_nettype none
module clock_switch (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [1:0] reqSel,
    input wire logic [2:0] srcTick,
    input wire logic gateOn,
    output logic tickOut,
    output logic [1:0] curSel
);
    import clock_source_pkg::*;

    switch_state_t stateReg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateReg <= SW_RUN;
            curSel <= SRC_LOOP;
            tickOut <= 1'b0;
        end else if (clkEn) begin
            tickOut <= 1'b0;
            case (stateReg)
                SW_RUN: begin
                    if (reqSel != curSel) begin
                        stateReg <= SW_DRAIN;
                    end else begin
                        tickOut <= srcTick[curSel] & gateOn;
                    end
                end
                // finish the old source on its own edge, then wait for the new one
                SW_DRAIN: begin
                    if (srcTick[curSel]) begin
                        tickOut <= gateOn;
                        stateReg <= SW_ARM;
                    end
                end
                SW_ARM: begin
                    if (srcTick[reqSel]) begin
                        curSel <= reqSel;
                        tickOut <= gateOn;
                        stateReg <= SW_RUN;
                    end
                end
                default: begin
                    stateReg <= SW_RUN;
                end
            endcase
        end
    end
endmodule : clock_switch
`default_nettype wire

/* design/clock_source_unit.sv */
// clock source unit: mode control, source switch, dividers and registers
// assumes loop and reference clocks arrive as ticks synchronous to clk
//
// Summary of operation
// RULE1: seven modes: two engaged, four bypassed, and stop.
// RULE2: any reset lands in loop engaged internal mode.
// RULE3: engaged internal: output from loop on internal reference, debug from loop.
// RULE4: engaged external: output from loop on external reference, debug from loop.
// RULE5: bypassed internal: loop runs, output from internal reference, debug from loop.
// RULE6: internal low power: loop off, output internal reference, no debug clock.
// RULE7: bypassed external: loop runs, output external reference, debug from loop.
// RULE8: external low power: loop off, output external reference, no debug clock.
// RULE9: stop: loop off, no outputs, references follow their stop enables.
// RULE10: debug clock is loop output divided by two, independent of bus divider.
// RULE11: source select picks loop, internal or external; code three acts as loop.
// RULE12: selected source divided by 1, 2, 4 or 8 via two-bit field.
// RULE13: reference divider codes give 1..32, code six gives 128, resets to zero.
// RULE14: software keeps divided loop reference between 31.25 and 39.0625 kHz.
// RULE15: reference select one picks internal, zero picks external reference.
// RULE16: internal output enable drives internal reference onto its peripheral clock.
// RULE17: stop enable keeps internal reference alive if enabled or previously used.
// RULE18: software enables regulator in stop whenever internal reference stays on.
// RULE19: nine trim bits: eight coarse plus one fine in status register.
// RULE20: outputs range, high gain, oscillator select, external enable, stop enable.
// RULE21: bus divider field resets to code one, divide by two.
// RULE22: clock mode status follows source only after the switch completes.
// RULE23: power-on loads trim 0x80 and fine zero; other resets keep trim.
// RULE24: bus clock is half the unit output clock.
// RULE25: source changes go through a glitch-free switch.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module clock_source_unit #(
    parameter int REF_DIV_WIDTH = 7,
    parameter int BUS_DIV_WIDTH = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic porRst,
    input wire logic clkEn,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic loopTick,
    input wire logic intRefTick,
    input wire logic extRefTick,
    input wire logic stopReq,
    input wire logic debugActive,
    input wire logic oscReady,
    output logic unitOutTick,
    output logic busTick,
    output logic debugTick,
    output logic loopRefTick,
    output logic intRefPeriphTick,
    output logic extRefPeriphTick,
    output logic loopEnable,
    output logic intRefEnable,
    output logic extRefEnable,
    output logic extRefStopEnable,
    output logic oscRange,
    output logic oscHighGain,
    output logic oscSelect,
    output logic [7:0] coarseTrim,
    output logic fineTrim,
    output clock_source_pkg::mode_t modeStatus
);
    import clock_source_pkg::*;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0] ctrlOneReg;
    logic [7:0] ctrlTwoReg;
    logic [7:0] coarseTrimReg;
    logic fineTrimReg, refStatusReg, waitReg, writeNow;
    logic [31:0] readReg;
    logic [7:0] readMux;
    logic [1:0] statusSel;

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    logic [1:0] srcSelField, srcSelEff, busDivField;
    logic [2:0] refDivField, refDivLog2;
    logic refSel, intOutEn, intStopEn, lowPower, extOutEn, extStopEn;

    always_comb begin
        srcSelField = ctrlOneReg[SRC_SEL_HI:SRC_SEL_LO];
        refDivField = ctrlOneReg[REF_DIV_HI:REF_DIV_LO];
        refSel = ctrlOneReg[REF_SEL_BIT];
        intOutEn = ctrlOneReg[INT_OUT_EN_BIT];
        intStopEn = ctrlOneReg[INT_STOP_EN_BIT];
        busDivField = ctrlTwoReg[BUS_DIV_HI:BUS_DIV_LO];
        lowPower = ctrlTwoReg[LOW_POWER_BIT];
        extOutEn = ctrlTwoReg[EXT_OUT_EN_BIT];
        extStopEn = ctrlTwoReg[EXT_STOP_EN_BIT];
        // reserved source code acts as the loop; unlisted divider code held at 128
        srcSelEff = (srcSelField == SRC_RESERVED) ? SRC_LOOP : srcSelField; // RULE11
        refDivLog2 = refDivField >= REF_DIV_CODE_128 ? REF_DIV_LOG2_128 : refDivField; // RULE13
    end

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, then a single ack cycle
    // ------------------------------------------------------------------
    always_comb begin
        case (address)
            ADDR_CTRL_ONE: readMux = ctrlOneReg;
            ADDR_CTRL_TWO: readMux = ctrlTwoReg;
            ADDR_TRIM: readMux = coarseTrimReg;
            ADDR_STATUS: readMux = {3'h0, refStatusReg, statusSel, oscReady, fineTrimReg};
            default: readMux = 8'h00;
        endcase
    end

    always_comb begin
        writeNow = write && !waitReg && byteenable[0];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitReg <= 1'b1;
            readReg <= READ_DATA_RESET;
        end else if (clkEn) begin
            if ((read || write) && waitReg) begin
                waitReg <= 1'b0;
                readReg <= read ? {24'h000000, readMux} : READ_DATA_RESET;
            end else begin
                waitReg <= 1'b1;
            end
        end
    end

    always_comb begin
        readdata = readReg;
        waitrequest = waitReg;
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlOneReg <= CTRL_ONE_RESET; // RULE2
            ctrlTwoReg <= CTRL_TWO_RESET; // RULE21
        end else if (clkEn && writeNow) begin
            if (address == ADDR_CTRL_ONE) begin
                ctrlOneReg <= writedata[7:0];
            end
            if (address == ADDR_CTRL_TWO) begin
                ctrlTwoReg <= writedata[7:0];
            end
        end
    end

    // trim survives system reset; only power-on reloads it
    always_ff @(posedge clk) begin
        if (porRst) begin
            coarseTrimReg <= COARSE_TRIM_POR; // RULE23
            fineTrimReg <= FINE_TRIM_POR; // RULE23
        end else if (clkEn && writeNow) begin
            if (address == ADDR_TRIM) begin
                coarseTrimReg <= writedata[7:0]; // RULE19
            end
            if (address == ADDR_STATUS) begin
                fineTrimReg <= writedata[FINE_TRIM_BIT]; // RULE19
            end
        end
    end

    // ------------------------------------------------------------------
    // source switch and bus dividers
    // ------------------------------------------------------------------
    logic switchTick, refTickSel;

    clock_switch u_switch (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .reqSel(srcSelEff),
        .srcTick({extRefTick, intRefTick, loopTick}),
        .gateOn(!stopReq),
        .tickOut(switchTick),
        .curSel(statusSel)
    ); // RULE25 RULE22

    tick_divider #(
        .CW(BUS_DIV_WIDTH)
    ) u_bus_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .tickIn(switchTick),
        .log2Div({1'b0, busDivField}),
        .tickOut(unitOutTick)
    ); // RULE12

    // a second stage ahead of the bus keeps the fixed halving
    tick_divider #(
        .CW(BUS_DIV_WIDTH)
    ) u_bus_half (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .tickIn(unitOutTick),
        .log2Div(BUS_HALF_LOG2),
        .tickOut(busTick)
    ); // RULE24

    // ------------------------------------------------------------------
    // loop reference path
    // ------------------------------------------------------------------
    always_comb begin
        refTickSel = refSel ? intRefTick : extRefTick; // RULE15
    end

    tick_divider #(
        .CW(REF_DIV_WIDTH)
    ) u_ref_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .tickIn(refTickSel & loopEnable),
        .log2Div(refDivLog2),
        .tickOut(loopRefTick)
    ); // RULE13

    // reference status lags the select until the new source ticks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refStatusReg <= CTRL_ONE_RESET[REF_SEL_BIT];
        end else if (clkEn && refTickSel) begin
            refStatusReg <= refSel;
        end
    end

    // ------------------------------------------------------------------
    // debug clock: loop halved, only when the loop runs
    // ------------------------------------------------------------------
    tick_divider #(
        .CW(BUS_DIV_WIDTH)
    ) u_debug_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .tickIn(loopTick & loopEnable),
        .log2Div(DEBUG_DIV_LOG2),
        .tickOut(debugTick)
    ); // RULE10

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    mode_t modeNext, lastRunMode;
    logic lowPowerEff;

    always_comb begin
        // low power only disables the loop while debug is not using it
        lowPowerEff = lowPower && !debugActive;
        if (stopReq) begin
            modeNext = MODE_STOP; // RULE9
        end else begin
            case (statusSel)
                SRC_LOOP: modeNext = refSel ? MODE_LOOP_ENGAGED_INTERNAL
                    : MODE_LOOP_ENGAGED_EXTERNAL; // RULE3 RULE4
                SRC_INTERNAL: modeNext = lowPowerEff ? MODE_BYPASSED_INTERNAL_LOW_POWER
                    : MODE_LOOP_BYPASSED_INTERNAL; // RULE5 RULE6
                SRC_EXTERNAL: modeNext = lowPowerEff ? MODE_BYPASSED_EXTERNAL_LOW_POWER
                    : MODE_LOOP_BYPASSED_EXTERNAL; // RULE7 RULE8
                default: modeNext = MODE_LOOP_ENGAGED_INTERNAL; // RULE1
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeStatus <= MODE_LOOP_ENGAGED_INTERNAL; // RULE2
            lastRunMode <= MODE_LOOP_ENGAGED_INTERNAL;
        end else if (clkEn) begin
            modeStatus <= modeNext; // RULE1
            if (modeNext != MODE_STOP) begin
                lastRunMode <= modeNext;
            end
        end
    end

    // ------------------------------------------------------------------
    // enables toward loop, references and oscillator
    // ------------------------------------------------------------------
    logic prevInternal, prevExternal, usesExternal;
    logic intRunNext, extRunNext, loopRunNext;

    always_comb begin
        prevInternal = (lastRunMode == MODE_LOOP_ENGAGED_INTERNAL)
            || (lastRunMode == MODE_LOOP_BYPASSED_INTERNAL)
            || (lastRunMode == MODE_BYPASSED_INTERNAL_LOW_POWER);
        prevExternal = (lastRunMode == MODE_LOOP_ENGAGED_EXTERNAL)
            || (lastRunMode == MODE_LOOP_BYPASSED_EXTERNAL)
            || (lastRunMode == MODE_BYPASSED_EXTERNAL_LOW_POWER);
        usesExternal = (modeNext == MODE_LOOP_ENGAGED_EXTERNAL)
            || (modeNext == MODE_LOOP_BYPASSED_EXTERNAL)
            || (modeNext == MODE_BYPASSED_EXTERNAL_LOW_POWER);
        loopRunNext = (modeNext != MODE_STOP)
            && (modeNext != MODE_BYPASSED_INTERNAL_LOW_POWER)
            && (modeNext != MODE_BYPASSED_EXTERNAL_LOW_POWER); // RULE6 RULE8 RULE9
        if (stopReq) begin
            intRunNext = intStopEn && (intOutEn || prevInternal); // RULE17
            extRunNext = extStopEn && (extOutEn || prevExternal); // RULE9
        end else begin
            // internal reference always runs: it is the fallback source
            intRunNext = 1'b1;
            extRunNext = extOutEn || usesExternal || !refSel;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loopEnable <= 1'b1;
            intRefEnable <= 1'b1;
            extRefEnable <= 1'b0;
            intRefPeriphTick <= 1'b0;
            extRefPeriphTick <= 1'b0;
        end else if (clkEn) begin
            loopEnable <= loopRunNext;
            intRefEnable <= intRunNext;
            extRefEnable <= extRunNext; // RULE20
            intRefPeriphTick <= intRefTick & intOutEn & intRunNext; // RULE16
            extRefPeriphTick <= extRefTick & extOutEn & extRunNext;
        end
    end

    // oscillator control and trim pins mirror their fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oscRange <= CTRL_TWO_RESET[RANGE_BIT];
            oscHighGain <= CTRL_TWO_RESET[HIGH_GAIN_BIT];
            oscSelect <= CTRL_TWO_RESET[OSC_SEL_BIT];
            extRefStopEnable <= CTRL_TWO_RESET[EXT_STOP_EN_BIT];
        end else if (clkEn) begin
            oscRange <= ctrlTwoReg[RANGE_BIT]; // RULE20
            oscHighGain <= ctrlTwoReg[HIGH_GAIN_BIT]; // RULE20
            oscSelect <= ctrlTwoReg[OSC_SEL_BIT]; // RULE20
            extRefStopEnable <= extStopEn; // RULE20
        end
    end

    always_ff @(posedge clk) begin
        if (porRst) begin
            coarseTrim <= COARSE_TRIM_POR;
            fineTrim <= FINE_TRIM_POR;
        end else if (clkEn) begin
            coarseTrim <= coarseTrimReg; // RULE19
            fineTrim <= fineTrimReg; // RULE19
        end
    end
endmodule : clock_source_unit
`default_nettype wire

/* sim/clock_source_sva.sv */
// port assertions for clock_source_unit
// assumes clkEn held high; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module clock_source_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic loopTick,
    input wire logic intRefTick,
    input wire logic extRefTick,
    input wire logic stopReq,
    input wire logic unitOutTick,
    input wire logic busTick,
    input wire logic debugTick,
    input wire logic loopRefTick,
    input wire logic intRefPeriphTick,
    input wire logic extRefPeriphTick,
    input wire logic loopEnable,
    input wire clock_source_pkg::mode_t modeStatus
);
    import clock_source_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RST_MODE: assert property ($past(sys_rst) |->
        modeStatus == MODE_LOOP_ENGAGED_INTERNAL && loopEnable) else $error("reset mode");
    AST_DBG_HALF: assert property (debugTick |-> $past(loopTick))
        else $error("debug tick");
    AST_LP_QUIET: assert property (!loopEnable && !$past(loopEnable) |->
        !debugTick && !loopRefTick) else $error("loop off ticks");
    AST_STOP_QUIET: assert property (stopReq [*4] |->
        !unitOutTick && !loopEnable && modeStatus == MODE_STOP) else $error("stop");
    AST_BUS_HALF: assert property (busTick |-> $past(unitOutTick))
        else $error("bus tick");
    AST_OUT_SRC: assert property (unitOutTick |->
        $past(loopTick, 2) || $past(intRefTick, 2) || $past(extRefTick, 2)) else $error("out");
    AST_INT_OUT: assert property (intRefPeriphTick |-> $past(intRefTick))
        else $error("int periph");
    AST_EXT_OUT: assert property (extRefPeriphTick |-> $past(extRefTick))
        else $error("ext periph");
endmodule : clock_source_sva
bind clock_source_unit clock_source_sva sva (.clk, .sys_rst, .loopTick, .intRefTick,
    .extRefTick, .stopReq, .unitOutTick, .busTick, .debugTick, .loopRefTick,
    .intRefPeriphTick, .extRefPeriphTick, .loopEnable, .modeStatus);
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for clock_source_unit
// assumes package and design compiled first; ticks come every 2, 3 and 5 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clock_source_pkg::*;
    logic clk, sys_rst, porRst, read, write, stopReq, meas;
    logic [3:0] address;
    logic [31:0] writedata, readdata;
    logic waitrequest, loopTick, intRefTick, extRefTick, loopEnable, intRefEnable;
    logic oscRange, oscHighGain, oscSelect, extRefStopEnable, fineTrim;
    logic [5:0] tk;
    logic [7:0] coarseTrim, rd;
    mode_t modeStatus;
    int errors, checks_done, cyc, n[6];
    clock_source_unit dut (.clk, .sys_rst, .porRst, .clkEn(1'b1), .address, .read, .write,
        .writedata, .byteenable(4'h1), .readdata, .waitrequest, .loopTick, .intRefTick,
        .extRefTick, .stopReq, .debugActive(1'b0), .oscReady(1'b0), .unitOutTick(tk[0]),
        .busTick(tk[1]), .debugTick(tk[2]), .loopRefTick(tk[3]), .intRefPeriphTick(tk[4]),
        .extRefPeriphTick(tk[5]), .loopEnable, .intRefEnable, .extRefEnable(),
        .extRefStopEnable, .oscRange, .oscHighGain, .oscSelect, .coarseTrim, .fineTrim,
        .modeStatus);
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        loopTick <= cyc % 2 == 0;
        intRefTick <= cyc % 3 == 0;
        extRefTick <= cyc % 5 == 0;
        if (meas) foreach (n[i]) n[i] += tk[i];
    end
    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rst(input logic p);
        sys_rst <= 1'b1;
        porRst <= p;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        porRst <= 1'b0;
    endtask : rst
    // settle, then count output ticks over c cycles
    task automatic run(input int c);
        repeat (40) @(posedge clk);
        n = '{default: 0};
        meas <= 1'b1;
        repeat (c) @(posedge clk);
        meas <= 1'b0;
        @(negedge clk);
    endtask : run
    task automatic t_regs;
        bus(0, ADDR_CTRL_ONE, 0);
        chk(rd === 8'h04 && modeStatus === MODE_LOOP_ENGAGED_INTERNAL, "ctrl1 reset");
        bus(0, ADDR_CTRL_TWO, 0);
        chk(rd === 8'h40, "ctrl2 reset");
        bus(0, ADDR_TRIM, 0);
        chk(rd === 8'h80, "trim por");
        bus(1, ADDR_TRIM, 8'h35);
        bus(1, ADDR_STATUS, 8'hff);
        rst(1'b0);
        bus(0, ADDR_TRIM, 0);
        chk(rd === 8'h35 && coarseTrim === 8'h35, "trim kept");
        bus(0, ADDR_STATUS, 0);
        chk(rd[0] === 1'b1 && rd[7:5] === 3'h0 && fineTrim === 1'b1, "fine trim");
        bus(0, 4'h2, 0);
        chk(rd === 8'h00, "unmapped");
        $display("regs done");
    endtask : t_regs
    task automatic t_div;
        for (int k = 0; k < 4; k++) begin
            bus(1, ADDR_CTRL_TWO, 8'(k << 6));
            run(480);
            chk(n[0] == 240 >> k && n[1] == 120 >> k, "bus div");
        end
        for (int k = 0; k < 7; k++) begin
            bus(1, ADDR_CTRL_ONE, 8'(4 | k << 3));
            run(1920);
            chk(n[3] == (k < 6 ? 640 >> k : 5), "ref div");
        end
        bus(1, ADDR_CTRL_ONE, 8'h00);
        run(60);
        chk(n[3] == 12, "ref select");
        $display("dividers done");
    endtask : t_div
    task automatic t_modes;
        logic [7:0] c1[7] = '{8'h04, 8'h44, 8'h44, 8'h00, 8'h80, 8'h80, 8'hc4};
        logic [7:0] c2[7] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00};
        logic [2:0] md[7] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h0};
        int u[7] = '{30, 20, 20, 30, 12, 12, 30};
        int d[7] = '{15, 15, 0, 15, 15, 0, 15};
        for (int i = 0; i < 7; i++) begin
            bus(1, ADDR_CTRL_TWO, c2[i]);
            bus(1, ADDR_CTRL_ONE, c1[i]);
            repeat (2) @(negedge clk);
            if (i == 1) chk(modeStatus === 3'h0, "status lag");
            run(60);
            chk(modeStatus === md[i], "mode");
            chk(n[0] == u[i] && n[2] == d[i], "mode ticks");
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_stop;
        bus(1, ADDR_CTRL_TWO, 8'h37);
        bus(1, ADDR_CTRL_ONE, 8'h07);
        run(60);
        chk({oscRange, oscHighGain, oscSelect, extRefStopEnable} === 4'hf, "osc pins");
        chk(n[4] == 20 && n[5] == 12, "periph");
        @(posedge clk) stopReq <= 1'b1;
        run(60);
        chk(n[0] == 0 && n[2] == 0 && intRefEnable === 1'b1 && n[4] == 20, "stop");
        bus(1, ADDR_CTRL_ONE, 8'h06);
        repeat (4) @(negedge clk);
        chk(intRefEnable === 1'b0 && loopEnable === 1'b0, "int stopped");
        @(posedge clk) stopReq <= 1'b0;
        bus(1, ADDR_CTRL_ONE, 8'h04);
        run(60);
        chk(n[4] == 0 && loopEnable === 1'b1, "periph off");
        $display("stop done");
    endtask : t_stop
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {read, write, stopReq, meas} = 4'h0;
        {sys_rst, porRst, address, writedata, cyc} = '0;
        rst(1'b1);
        t_regs();
        t_div();
        t_modes();
        t_stop();
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
